// [rtl/tsf_store.sv]
// egress time stamp store with packing, register readout and serial push
// Function
// - store exists for egress stamps only
// - each saved entry and overflow raise events
// - keep configured signature bytes, pack tightly
// - full entry is 208 bits, 26 bytes
// - no signature: 10 bytes, or 4
// - write store word at 26 packed bytes
// - word0 bit 31 shows store empty
// - reading seventh word pops the store
// - flush partial packer when reads drain store
// - three flag bits count stamps starting here
// - level alert at threshold, level readable
// - overflow blocks writes, drops new stamps
// - serial push enabled makes the seven word registers invalid
// - serial port drives data, clock, select
// - round robin among enabled non-empty ports
// - one-entry staging buffer per port
// - select, command 1, 0, address, data
// - address phase five bits, port number
// - data length per config, msb first
// - clock high and low counts programmable
// - lead, lag, gap, polarity programmable
// - count sent pairs and dropped pairs
`timescale 1ns/1ns
module tsf_store #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic port_clk,
  input wire logic [tsf_pkg::CH_N-1:0] ts_valid,
  input wire tsf_pkg::tsf_entry_t [tsf_pkg::CH_N-1:0] ts_entry,
  output logic [tsf_pkg::CH_N-1:0] ts_ready,
  input wire tsf_pkg::tsf_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output tsf_pkg::tsf_ser_pins_t pins,
  output logic [tsf_pkg::CH_N-1:0] stamp_saved,
  output logic [tsf_pkg::CH_N-1:0] store_overflow,
  output logic [tsf_pkg::CH_N-1:0] level_alert
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // level must fit the 8-bit field and pointers need a power of two
  if (DEPTH < 2 || DEPTH > 128 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 128");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // port clock side: one holding slot per processor, toggle handshake
  typedef struct packed {
    tsf_pkg::tsf_entry_t [1:0] hold;  // stable while request pending
    logic [1:0] req;                  // request toggles
    logic [1:0] ack_s1;               // first sync stage
    logic [1:0] ack_s2;               // second sync stage
    logic [1:0] rdy;                  // slot free
  } tsf_port_t;

  // register clock side
  typedef struct packed {
    logic [1:0][415:0] pk_acc;   // packing accumulator, left aligned
    logic [1:0][5:0] pk_cnt;     // valid bytes in accumulator
    logic [1:0][51:0] pk_start;  // byte marks where a stamp begins
    logic [1:0] flush;           // pending partial flush
    logic [1:0] ovf;             // sticky overflow
    logic [1:0][AW:0] wr_ptr;
    logic [1:0][AW:0] rd_ptr;
    logic [1:0][415:0] up_acc;   // unpacking accumulator
    logic [1:0][5:0] up_cnt;
    logic [1:0] stage_full;      // staging buffer occupied
    logic [1:0][207:0] stage;
    logic [1:0][31:0] csr;
    logic [31:0] scfg;
    logic [1:0][15:0] sent_cnt;
    logic [1:0][15:0] drop_cnt;
    logic [1:0] req_s1;          // sync stage one, read only by stage two
    logic [1:0] req_s2;
    logic [1:0] req_s3;          // last request taken, doubles as ack
    tsf_pkg::tsf_ser_st_t st;
    logic [7:0] tmr;             // phase timer, counts down to 1
    logic [7:0] bits_left;
    logic [214:0] shreg;         // command, address, data
    logic ser_ch;
    logic last_ch;
    logic sdo;
    logic sclk;
    logic sel_n;
    logic [31:0] rdata;
    logic [1:0] saved_ev;
    logic [1:0] ovf_ev;
    logic [1:0] lvl_irq;
  } tsf_state_t;

  tsf_port_t p_q, p_d;
  tsf_state_t r_q, r_d;
  logic [215:0] mem [2][DEPTH];  // store words per processor
  logic [1:0] mem_we;
  logic [1:0][215:0] mem_wd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // zero counts would stall, so a zero reads as one cycle
  function automatic logic [7:0] tsf_ld(input logic [3:0] n);
    return (n == 4'h0) ? 8'h01 : {4'h0, n};
  endfunction

  // bytes per entry for a processor's settings
  function automatic logic [5:0] tsf_len(input logic [31:0] csr);
    logic [4:0] sig;
    logic [5:0] base;
    sig = csr[tsf_pkg::CSR_SIG_POS +: 5];
    if (sig > 5'(tsf_pkg::SIG_MAX_BYTES)) begin
      sig = 5'(tsf_pkg::SIG_MAX_BYTES);
    end
    base = csr[tsf_pkg::CSR_FOUR_POS] ? 6'(tsf_pkg::STAMP_SHORT_BYTES)
                                      : 6'(tsf_pkg::STAMP_FULL_BYTES);
    return base + {1'b0, sig};
  endfunction

  // keep only the leading len bytes of a left-aligned value
  function automatic logic [207:0] tsf_keep(input logic [207:0] v, input logic [5:0] len);
    return v & ~({208{1'b1}} >> {len, 3'h0});
  endfunction

  // ----------------------------------------------------------------
  // port clock domain: capture stamps, hand over by toggle
  // ----------------------------------------------------------------
  always_comb begin
    p_d = p_q;
    p_d.ack_s1 = r_q.req_s3;
    p_d.ack_s2 = p_q.ack_s1;
    for (int c = 0; c < 2; c++) begin
      // a stamp offered while the slot is busy is held off by ts_ready
      if (ts_valid[c] && p_q.rdy[c]) begin
        p_d.hold[c] = ts_entry[c];
        p_d.req[c] = ~p_q.req[c];
      end
    end
    p_d.rdy = ~(p_d.req ^ p_d.ack_s2);
  end

  // port side register
  always_ff @(posedge port_clk or negedge reset_n) begin
    if (!reset_n) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  assign ts_ready = p_q.rdy;

  // ----------------------------------------------------------------
  // register clock domain: pack, store, unpack, registers, serial
  // ----------------------------------------------------------------
  always_comb begin
    logic ch;
    logic [3:0] idx;
    logic [5:0] len;
    logic [207:0] ent;
    logic [4:0] pc;
    logic [4:0] nb;
    logic [AW:0] lvl;
    logic empty;
    logic push;
    logic take;
    logic cpu_pop;
    logic ser_pop;
    tsf_pkg::tsf_word_t wd;
    tsf_pkg::tsf_word_t hw;
    logic [223:0] line;
    logic [1:0] en;
    logic [1:0] rdy;
    logic pick;
    ch = reg_req.addr[4];
    idx = reg_req.addr[3:0];
    len = '0;
    ent = '0;
    pc = '0;
    nb = '0;
    lvl = '0;
    empty = 1'b0;
    push = 1'b0;
    take = 1'b0;
    cpu_pop = 1'b0;
    ser_pop = 1'b0;
    wd = '0;
    hw = '0;
    line = '0;
    en = r_q.scfg[tsf_pkg::SC_EN_POS +: 2];
    rdy = '0;
    pick = 1'b0;
    r_d = r_q;
    r_d.req_s1 = p_q.req;
    r_d.req_s2 = r_q.req_s1;
    r_d.saved_ev = '0;
    r_d.ovf_ev = '0;
    mem_we = '0;
    mem_wd = '0;

    // software writes; overflow clear comes first so a new overflow wins
    if (reg_req.wr) begin
      if (idx == tsf_pkg::REG_CSR) begin
        r_d.csr[ch] = (r_q.csr[ch] & ~tsf_pkg::CSR_WR_MASK) |
                      (reg_req.wdata & tsf_pkg::CSR_WR_MASK);
        if (reg_req.wdata[tsf_pkg::CSR_OVF_POS]) begin
          r_d.ovf[ch] = 1'b0;
        end
      end else if (idx == tsf_pkg::REG_SCFG) begin
        r_d.scfg = reg_req.wdata & tsf_pkg::SCFG_WR_MASK;
      end
    end

    for (int c = 0; c < 2; c++) begin
      len = tsf_len(r_q.csr[c]);
      lvl = r_q.wr_ptr[c] - r_q.rd_ptr[c];
      empty = (lvl == '0);
      hw = mem[c][r_q.rd_ptr[c][AW-1:0]];

      // full word or pending flush goes to the store; arrivals wait
      push = (r_q.pk_cnt[c] >= 6'(tsf_pkg::WORD_BYTES)) ||
             (r_q.flush[c] && r_q.pk_cnt[c] != 6'h0);
      take = (r_q.req_s2[c] != r_q.req_s3[c]) && !push;

      // new egress stamp: trim to configured size and append
      if (take) begin
        r_d.req_s3[c] = r_q.req_s2[c];
        r_d.saved_ev[c] = 1'b1;
        if (r_q.ovf[c]) begin
          r_d.drop_cnt[c] = r_q.drop_cnt[c] + 16'h0001;
        end else begin
          if (r_q.csr[c][tsf_pkg::CSR_FOUR_POS]) begin
            ent = {p_q.hold[c].stamp[31:0], p_q.hold[c].sig, 48'h0};
          end else begin
            ent = {p_q.hold[c].stamp, p_q.hold[c].sig};
          end
          ent = tsf_keep(ent, len);
          r_d.pk_acc[c] = r_q.pk_acc[c] | ({ent, 208'h0} >> {r_q.pk_cnt[c], 3'h0});
          r_d.pk_start[c] = r_q.pk_start[c] | ({1'b1, 51'h0} >> r_q.pk_cnt[c]);
          r_d.pk_cnt[c] = r_q.pk_cnt[c] + len;
        end
      end

      // write one packed word, end to end, with its start count
      if (push) begin
        nb = (r_q.pk_cnt[c] >= 6'(tsf_pkg::WORD_BYTES)) ?
             5'(tsf_pkg::WORD_BYTES) : r_q.pk_cnt[c][4:0];
        pc = '0;
        for (int b = 26; b < 52; b++) begin
          pc = pc + {4'h0, r_q.pk_start[c][b]};
        end
        wd.flags = (pc > 5'h07) ? 3'h7 : pc[2:0];
        wd.nbytes = nb;
        wd.data = r_q.pk_acc[c][415:208];
        if (r_q.ovf[c] || lvl == (AW+1)'(DEPTH)) begin
          r_d.ovf[c] = 1'b1;
          r_d.ovf_ev[c] = 1'b1;
          r_d.drop_cnt[c] = r_d.drop_cnt[c] + 16'h0001;
        end else begin
          mem_we[c] = 1'b1;
          mem_wd[c] = wd;
        end
        r_d.pk_acc[c] = r_q.pk_acc[c] << 208;
        r_d.pk_start[c] = r_q.pk_start[c] << 26;
        r_d.pk_cnt[c] = r_q.pk_cnt[c] - {1'b0, nb};
        r_d.flush[c] = 1'b0;
      end

      // pops: seventh word read, or the unpacker wanting more bytes
      cpu_pop = reg_req.rd && ch == 1'(c) && idx == tsf_pkg::REG_WORD6 &&
                !en[c] && !empty;
      ser_pop = en[c] && !empty && r_q.up_cnt[c] < len;
      if (cpu_pop || ser_pop) begin
        r_d.rd_ptr[c] = r_q.rd_ptr[c] + 1'b1;
      end
      if (ser_pop) begin
        r_d.up_acc[c] = r_q.up_acc[c] | ({hw.data, 208'h0} >> {r_q.up_cnt[c], 3'h0});
        r_d.up_cnt[c] = r_q.up_cnt[c] + {1'b0, hw.nbytes};
      end else if (!r_q.stage_full[c] && r_q.up_cnt[c] >= len && r_q.up_cnt[c] != 6'h0) begin
        // unpack one pair into the staging buffer
        r_d.stage[c] = tsf_keep(r_q.up_acc[c][415:208], len);
        r_d.stage_full[c] = 1'b1;
        r_d.up_acc[c] = r_q.up_acc[c] << {len, 3'h0};
        r_d.up_cnt[c] = r_q.up_cnt[c] - len;
      end

      // drained store with bytes left in the packer: flush them
      // only when bytes remain, else a stale flush cuts the next word short
      if (((cpu_pop && lvl == (AW+1)'(1)) ||
           (reg_req.rd && ch == 1'(c) && idx == tsf_pkg::REG_WORD0 && empty) ||
           (en[c] && empty && r_q.up_cnt[c] < len)) && r_d.pk_cnt[c] != 6'h0) begin
        r_d.flush[c] = 1'b1;
      end
      if (mem_we[c]) begin
        r_d.wr_ptr[c] = r_q.wr_ptr[c] + 1'b1;
      end

      // level alert while fill reaches the threshold
      r_d.lvl_irq[c] = r_q.csr[c][tsf_pkg::CSR_MASK_POS] &&
                       (8'(lvl) >= r_q.csr[c][tsf_pkg::CSR_THR_POS +: 8]);
    end

    // register read data, one cycle after the strobe
    if (reg_req.rd) begin
      lvl = r_q.wr_ptr[ch] - r_q.rd_ptr[ch];
      hw = mem[ch][r_q.rd_ptr[ch][AW-1:0]];
      line = {(lvl == '0), hw.flags, 12'h000, hw.data};
      if (idx == tsf_pkg::REG_CSR) begin
        r_d.rdata = r_q.csr[ch];
        r_d.rdata[tsf_pkg::CSR_OVF_POS] = r_q.ovf[ch];
        r_d.rdata[tsf_pkg::CSR_LVL_POS +: 8] = 8'(lvl);
      end else if (idx >= tsf_pkg::REG_WORD0 && idx <= tsf_pkg::REG_WORD6) begin
        if (en[ch]) begin
          r_d.rdata = tsf_pkg::INVALID_WORD;
        end else begin
          r_d.rdata = 32'(line >> (32 * (int'(tsf_pkg::REG_WORD6) - int'(idx))));
        end
      end else if (idx == tsf_pkg::REG_COUNT) begin
        r_d.rdata = {r_q.drop_cnt[ch], r_q.sent_cnt[ch]};
      end else if (idx == tsf_pkg::REG_SCFG) begin
        r_d.rdata = r_q.scfg;
      end else begin
        r_d.rdata = 32'h0000_0000;
      end
    end

    // serial push engine; timer reloads count whole clk cycles
    rdy = r_q.stage_full & en;
    unique case (r_q.st)
      tsf_pkg::SER_IDLE: begin
        r_d.sclk = r_q.scfg[tsf_pkg::SC_POL_POS];
        r_d.sel_n = 1'b1;
        pick = rdy[~r_q.last_ch] ? ~r_q.last_ch : r_q.last_ch;
        if (rdy != 2'h0) begin
          len = tsf_len(r_q.csr[pick]);
          r_d.ser_ch = pick;
          r_d.shreg = {tsf_pkg::CMD_BITS, 4'h0, pick, r_q.stage[pick]};
          r_d.bits_left = 8'(tsf_pkg::HEAD_BITS) + {len[4:0], 3'h0};
          r_d.sel_n = 1'b0;
          r_d.tmr = tsf_ld(r_q.scfg[tsf_pkg::SC_LEAD_POS +: 4]);
          r_d.st = tsf_pkg::SER_LEAD;
        end
      end
      tsf_pkg::SER_LEAD: begin
        r_d.tmr = r_q.tmr - 8'h01;
        if (r_q.tmr == 8'h01) begin
          r_d.sdo = r_q.shreg[214];
          r_d.tmr = tsf_ld(r_q.scfg[tsf_pkg::SC_LO_POS +: 4]);
          r_d.st = tsf_pkg::SER_LOW;
        end
      end
      tsf_pkg::SER_LOW: begin
        r_d.tmr = r_q.tmr - 8'h01;
        if (r_q.tmr == 8'h01) begin
          r_d.sclk = ~r_q.scfg[tsf_pkg::SC_POL_POS];
          r_d.tmr = tsf_ld(r_q.scfg[tsf_pkg::SC_HI_POS +: 4]);
          r_d.st = tsf_pkg::SER_HIGH;
        end
      end
      tsf_pkg::SER_HIGH: begin
        r_d.tmr = r_q.tmr - 8'h01;
        if (r_q.tmr == 8'h01) begin
          r_d.sclk = r_q.scfg[tsf_pkg::SC_POL_POS];
          r_d.bits_left = r_q.bits_left - 8'h01;
          if (r_q.bits_left == 8'h01) begin
            // last bit done: release the staging buffer
            r_d.stage_full[r_q.ser_ch] = 1'b0;
            r_d.sent_cnt[r_q.ser_ch] = r_q.sent_cnt[r_q.ser_ch] + 16'h0001;
            r_d.tmr = tsf_ld(r_q.scfg[tsf_pkg::SC_LAG_POS +: 4]);
            r_d.st = tsf_pkg::SER_LAG;
          end else begin
            r_d.shreg = r_q.shreg << 1;
            r_d.sdo = r_q.shreg[213];
            r_d.tmr = tsf_ld(r_q.scfg[tsf_pkg::SC_LO_POS +: 4]);
            r_d.st = tsf_pkg::SER_LOW;
          end
        end
      end
      tsf_pkg::SER_LAG: begin
        r_d.tmr = r_q.tmr - 8'h01;
        if (r_q.tmr == 8'h01) begin
          r_d.sel_n = 1'b1;
          r_d.tmr = tsf_ld(r_q.scfg[tsf_pkg::SC_GAP_POS +: 4]);
          r_d.st = tsf_pkg::SER_GAP;
        end
      end
      tsf_pkg::SER_GAP: begin
        r_d.tmr = r_q.tmr - 8'h01;
        if (r_q.tmr == 8'h01) begin
          r_d.last_ch = r_q.ser_ch;
          r_d.st = tsf_pkg::SER_IDLE;
        end
      end
    endcase
  end

  // register clock state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
      r_q.csr <= {2{tsf_pkg::CSR_RST}};
      r_q.scfg <= tsf_pkg::SCFG_RST;
      r_q.sel_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // store memory, no reset needed behind the pointers
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (mem_we[c]) begin
        mem[c][r_q.wr_ptr[c][AW-1:0]] <= mem_wd[c];
      end
    end
  end

  // outputs straight from flops
  assign reg_rdata = r_q.rdata;
  assign pins = '{data: r_q.sdo, clk: r_q.sclk, sel_n: r_q.sel_n};
  assign stamp_saved = r_q.saved_ev;
  assign store_overflow = r_q.ovf_ev;
  assign level_alert = r_q.lvl_irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence lead_done_s;
    r_q.st == tsf_pkg::SER_LEAD ##1 r_q.st == tsf_pkg::SER_LOW;
  endsequence

  sequence last_bit_s;
    r_q.st == tsf_pkg::SER_HIGH && r_q.bits_left == 8'h01 && r_q.tmr == 8'h01;
  endsequence

  select_idle_a: assert property (
    r_q.st == tsf_pkg::SER_IDLE && $past(r_q.st) == tsf_pkg::SER_GAP |->
    r_q.sel_n && r_q.sclk == r_q.scfg[tsf_pkg::SC_POL_POS])
    else $error("select or clock not idle between writes");
  command_bit_a: assert property (lead_done_s |-> r_q.sdo && !r_q.sel_n)
    else $error("first serial bit is not the write command");
  stage_release_a: assert property (
    last_bit_s |=> !r_q.stage_full[r_q.ser_ch] &&
    r_q.sent_cnt[r_q.ser_ch] == $past(r_q.sent_cnt[r_q.ser_ch]) + 16'h0001)
    else $error("staging buffer or sent count wrong after last bit");
  pop_on_read_a: assert property (
    reg_req.rd && reg_req.addr[3:0] == tsf_pkg::REG_WORD6 && !reg_req.addr[4] &&
    !r_q.scfg[tsf_pkg::SC_EN_POS] && r_q.wr_ptr[0] != r_q.rd_ptr[0]
    |=> r_q.rd_ptr[0] == $past(r_q.rd_ptr[0]) + 1'b1)
    else $error("seventh word read did not pop");
  empty_flag_a: assert property (
    reg_req.rd && reg_req.addr == 5'h01 &&
    !r_q.scfg[tsf_pkg::SC_EN_POS] && r_q.wr_ptr[0] == r_q.rd_ptr[0]
    |=> reg_rdata[tsf_pkg::W0_EMPTY_POS])
    else $error("empty flag missing on empty store");
  // any of the seven words of processor 1 while it pushes serially
  serial_invalid_a: assert property (
    reg_req.rd && reg_req.addr[4] && reg_req.addr[3:0] >= tsf_pkg::REG_WORD0 &&
    reg_req.addr[3:0] <= tsf_pkg::REG_WORD6 && r_q.scfg[tsf_pkg::SC_EN_POS + 1]
    |=> reg_rdata == tsf_pkg::INVALID_WORD)
    else $error("register readout valid while serial push enabled");
  overflow_hold_a: assert property (
    r_q.ovf[0] && !(reg_req.wr && reg_req.addr == 5'h00)
    |=> r_q.ovf[0] && r_q.wr_ptr[0] == $past(r_q.wr_ptr[0]))
    else $error("store written during overflow");
  // processor 0 keeps register readout, so its level can climb
  level_alert_a: assert property (
    r_q.csr[0][tsf_pkg::CSR_MASK_POS] &&
    8'(r_q.wr_ptr[0] - r_q.rd_ptr[0]) >= r_q.csr[0][tsf_pkg::CSR_THR_POS +: 8]
    |=> level_alert[0])
    else $error("level alert missing at threshold");

endmodule

// [rtl/tsf_pkg.sv]
// shared constants and carrier types for the egress time stamp store and serial push unit
package tsf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CH_N = 2;               // processors, one store each
  localparam int STAMP_BITS = 80;        // full time stamp
  localparam int SIG_BITS = 128;         // full frame signature
  localparam int ENTRY_BITS = 208;       // one packed word / one unpacked pair
  localparam int WORD_BYTES = 26;        // bytes per store word
  localparam int STAMP_FULL_BYTES = 10;  // time stamp bytes, normal mode
  localparam int STAMP_SHORT_BYTES = 4;  // time stamp bytes, four byte mode
  localparam int SIG_MAX_BYTES = 16;     // signature byte ceiling
  localparam int ACC_BITS = 416;         // packing accumulator, two words
  localparam int ACC_BYTES = 52;
  localparam int HEAD_BITS = 7;          // command, spare and address bits
  localparam logic [1:0] CMD_BITS = 2'h2; // write command 1 then 0

  // ----------------------------------------------------------------
  // register indices: address bit 4 picks the processor
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CSR = 4'h0;
  localparam logic [3:0] REG_WORD0 = 4'h1;
  localparam logic [3:0] REG_WORD6 = 4'h7;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_SCFG = 4'h9;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CSR_SIG_POS = 0;        // signature_byte_count, 5 bits
  localparam int CSR_FOUR_POS = 5;       // four_byte_stamp_mode
  localparam int CSR_MASK_POS = 6;       // level alert enable
  localparam int CSR_OVF_POS = 7;        // overflow flag, write 1 clears
  localparam int CSR_THR_POS = 8;        // level_threshold, 8 bits
  localparam int CSR_LVL_POS = 16;       // fill_level, 8 bits, read only
  localparam logic [31:0] CSR_WR_MASK = 32'h0000_FF7F;
  localparam logic [31:0] CSR_RST = 32'h0000_0410;
  localparam int W0_EMPTY_POS = 31;      // store_empty_flag
  localparam int W0_FLAGS_POS = 28;      // set_fill_flags, 3 bits
  localparam logic [31:0] INVALID_WORD = 32'h8000_0000;
  localparam int SC_LO_POS = 0;          // clock_low_cycles
  localparam int SC_HI_POS = 4;          // clock_high_cycles
  localparam int SC_LEAD_POS = 8;        // select_lead_cycles
  localparam int SC_LAG_POS = 12;        // select_lag_cycles
  localparam int SC_GAP_POS = 16;        // select_gap_cycles
  localparam int SC_POL_POS = 20;        // clock_polarity
  localparam int SC_EN_POS = 24;         // serial_push_enable, 2 bits
  localparam logic [31:0] SCFG_WR_MASK = 32'h031F_FFFF;
  localparam logic [31:0] SCFG_RST = 32'h0001_1133;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [STAMP_BITS-1:0] stamp;
    logic [SIG_BITS-1:0] sig;
  } tsf_entry_t;

  typedef struct packed {
    logic [2:0] flags;                   // stamps that begin in this word
    logic [4:0] nbytes;                  // valid bytes, below 26 after a flush
    logic [ENTRY_BITS-1:0] data;
  } tsf_word_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [31:0] wdata;
  } tsf_reg_req_t;

  typedef struct packed {
    logic data;
    logic clk;
    logic sel_n;
  } tsf_ser_pins_t;

  typedef enum logic [2:0] {
    SER_IDLE, SER_LEAD, SER_LOW, SER_HIGH, SER_LAG, SER_GAP
  } tsf_ser_st_t;

endpackage

// [bench/tsf_rx_model.sv]
// serial receiver model that keeps the last complete write
`timescale 1ns/1ns
module tsf_rx_model (
  input wire tsf_pkg::tsf_ser_pins_t pins,
  output logic [63:0] got_q,
  output logic [7:0] nbits_q
);
  logic [63:0] sh; // arrival order, msb first
  logic [7:0] n; // bits in the open window
  logic idle; // clock level seen as the window opens
  // ----------
  // capture
  // ----------
  initial begin
    sh = '0;
    n = 8'h00;
    idle = 1'b0;
    got_q = '0;
    nbits_q = 8'h00;
  end
  // new window: clear count and bits, note the idle clock level
  always @(negedge pins.sel_n) begin
    n = 8'h00;
    sh = '0;
    idle = pins.clk;
  end
  // sample as the clock leaves its idle level, either polarity
  always @(pins.clk) if (!pins.sel_n && pins.clk != idle) begin
    sh = {sh[62:0], pins.data};
    n = n + 8'h01;
  end
  // deselect closes the write
  always @(posedge pins.sel_n) begin
    got_q = sh;
    nbits_q = n;
  end
endmodule

// [bench/egress_timestamp_fifo_serial_push_tb.sv]
// self-checking bench for the time stamp store and its serial push
`timescale 1ns/1ns
module egress_timestamp_fifo_serial_push_tb;
  logic clk, reset_n, port_clk;
  logic [1:0] ts_valid, ts_ready, saved, ovf, alert;
  tsf_pkg::tsf_entry_t [1:0] ts_entry;
  tsf_pkg::tsf_reg_req_t reg_req;
  logic [31:0] reg_rdata;
  tsf_pkg::tsf_ser_pins_t pins;
  logic [63:0] got;
  logic [7:0] nbits;
  int mismatches, total_checks, cycles, nsaved, novf;
  tsf_store #(.DEPTH(8)) i_dut (.clk(clk), .reset_n(reset_n), .port_clk(port_clk),
    .ts_valid(ts_valid), .ts_entry(ts_entry), .ts_ready(ts_ready), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .pins(pins), .stamp_saved(saved), .store_overflow(ovf),
    .level_alert(alert));
  tsf_rx_model i_rx (.pins(pins), .got_q(got), .nbits_q(nbits));
  // ----------
  // clocks, watchdog
  // ----------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // port clock, phase unrelated to clk
  initial begin
    port_clk = 1'b0;
    #3;
    forever #80 port_clk = ~port_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (saved[0] === 1'b1) nsaved++;
    if (ovf[0] === 1'b1) novf++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [63:0] exp, logic [63:0] v);
    total_checks++;
    if (v !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, v);
    end
  endtask
  // one strobe cycle, answer one edge later
  task automatic rd(logic [4:0] a, output logic [31:0] v);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge clk) reg_req <= '0;
    @(negedge clk) v = reg_rdata;
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk) reg_req <= '{1'b0, 1'b1, a, d};
    @(posedge clk) reg_req <= '0;
  endtask
  // offer only into a free slot
  task automatic push(int ch, logic [79:0] s);
    do @(posedge port_clk); while (ts_ready[ch] !== 1'b1);
    ts_valid[ch] <= 1'b1;
    ts_entry[ch] <= '{s, 128'h0};
    @(posedge port_clk) ts_valid[ch] <= 1'b0;
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    logic [31:0] v;
    reset_n = 1'b1;
    ts_valid = '0;
    ts_entry = '0;
    reg_req = '0;
    #1 reset_n = 1'b0; // a real falling edge resets both clock domains at once
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(5'h00, v); chk("csr reset", 32'h0000_0410, v);
    rd(5'h01, v); chk("empty flag", 1, v[31]);
    $display("test reset done");
    wr(5'h00, 32'h0000_0020); // four byte stamps, no signature
    push(0, 80'h1234_5678);
    repeat (20) @(posedge clk);
    chk("saved pulses", 1, nsaved);
    rd(5'h01, v); // empty read flushes the packer
    rd(5'h01, v); chk("word0", 32'h1000_1234, v);
    rd(5'h02, v); chk("word1", 16'h5678, v[31:16]);
    rd(5'h07, v); // pops the set
    rd(5'h01, v); chk("empty after pop", 1, v[31]);
    $display("test readout done");
    wr(5'h00, 32'h0000_0250); // full entries, alert at level 2
    for (int i = 0; i < 10; i++) push(0, {16'hC0DE, 64'(i)}); // ninth and tenth drop
    repeat (20) @(posedge clk);
    chk("saved total", 11, nsaved);
    chk("overflow pulses", 1, novf);
    chk("level alert", 1, alert[0]);
    rd(5'h00, v); chk("csr overflow", 32'h0008_02D0, v);
    rd(5'h08, v); chk("drop count", 32'h0002_0000, v);
    rd(5'h01, v); chk("full word0", 32'h1000_C0DE, v);
    wr(5'h00, 32'h0000_02D0); // write 1 clears overflow
    rd(5'h00, v); chk("overflow clear", 32'h0008_0250, v);
    $display("test overflow done");
    wr(5'h09, 32'h0201_1133); // serial push for processor 1
    wr(5'h10, 32'h0000_0020);
    push(1, 80'h0A0B_0C0D);
    rd(5'h11, v); chk("invalid word", 32'h8000_0000, v);
    for (int i = 0; i < 800 && nbits == 8'h00; i++) @(posedge clk);
    chk("bit count", 39, nbits);
    chk("frame", {25'h0, 2'h2, 5'h01, 32'h0A0B_0C0D}, got);
    repeat (10) @(posedge clk);
    rd(5'h18, v); chk("sent count", 1, v[15:0]);
    wr(5'h09, 32'h0211_1133); // idle-high serial clock
    push(1, 80'h1122_3344);
    for (int i = 0; i < 800 && got[31:0] != 32'h1122_3344; i++) @(posedge clk);
    chk("inverted clock frame", {25'h0, 2'h2, 5'h01, 32'h1122_3344}, got);
    $display("test serial done");
    report_and_stop();
  end
endmodule
